/* File: tb/cmd_host_model.sv */
// Purpose: system bus controller model sending switch command text
// Assumes: one char offered per cycle, LF ends a command
// Notes:   idle char line shows the inverse of the last char sent
`timescale 1ns/1ps

module cmd_host_model (
  // clock
  input  wire logic       clk_in,
  // command text out
  output logic            cmd_valid_out,
  output logic [7:0]      cmd_char_out,
  input  wire logic       cmd_ready_in,
  // reply text in
  input  wire logic       reply_valid_in,
  input  wire logic [7:0] reply_char_in,
  output logic            reply_ready_out
);
  // idle lines at time zero
  initial begin
    cmd_valid_out   = 1'b0;
    cmd_char_out    = 8'h00;
    reply_ready_out = 1'b0;
  end

  // each char held until an edge sees ready
  task automatic send_text(input string s);
    for (int i = 0; i < s.len(); i++) begin
      cmd_valid_out = 1'b1;
      cmd_char_out  = s[i];
      while (cmd_ready_in !== 1'b1) begin
        @(posedge clk_in);
        #1;
      end
      @(posedge clk_in);
      #1;
    end
    cmd_valid_out = 1'b0;
    cmd_char_out  = ~cmd_char_out; // released line does not hold value
  endtask

  // take one reply char within a bounded wait
  task automatic get_reply(output logic [7:0] c, output bit got);
    got = 1'b0;
    c   = 8'h00;
    for (int n = 0; n < 20 && !got; n++) begin
      if (reply_valid_in === 1'b1) begin
        got             = 1'b1;
        c               = reply_char_in;
        reply_ready_out = 1'b1;
      end
      @(posedge clk_in);
      #1;
    end
    reply_ready_out = 1'b0;
  endtask
endmodule // cmd_host_model

/* File: tb/testbench.sv */
// Purpose: self-checking bench for the relay switch mode controller
// Assumes: 50 MHz clock, inputs driven 1 ns after the rising edge
// Notes:   command text comes from the host model instance
`timescale 1ns/1ps

module testbench;
  logic                        clk_in = 1'b0;
  logic                        rst_in = 1'b1;
  logic                        direct_mode, bus_reset;
  logic [3:0]                  dip;
  logic [63:0]                 readback, coil;
  logic                        cmd_valid, cmd_ready, reply_valid;
  logic                        reply_ready;
  logic [7:0]                  cmd_char, reply_char, status_data;
  logic [2:0]                  status_index;
  relay_switch_pkg::host_wr_s  host_wr;
  int                          miscompares = 0;
  int                          checks = 0;

  // clock of 20 ns period
  always #10 clk_in = ~clk_in;

  relay_switch_mode_control dut (
    .clk_in(clk_in), .rst_in(rst_in), .direct_mode_in(direct_mode),
    .bus_reset_in(bus_reset), .address_dip_switch_in(dip),
    .coil_readback_in(readback), .cmd_valid_in(cmd_valid),
    .cmd_char_in(cmd_char), .cmd_ready_out(cmd_ready),
    .reply_valid_out(reply_valid), .reply_char_out(reply_char),
    .reply_ready_in(reply_ready), .host_wr_in(host_wr),
    .status_index_in(status_index), .status_data_out(status_data),
    .relay_coil_out(coil));

  cmd_host_model host (
    .clk_in(clk_in), .cmd_valid_out(cmd_valid), .cmd_char_out(cmd_char),
    .cmd_ready_in(cmd_ready), .reply_valid_in(reply_valid),
    .reply_char_in(reply_char), .reply_ready_out(reply_ready));

  // compare and count
  task automatic check(string name, logic [63:0] exp, logic [63:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  // send one command and judge its reply char
  task automatic cmd_reply(string s, logic [7:0] exp);
    logic [7:0] c;
    bit         got;
    host.send_text(s);
    host.get_reply(c, got);
    check("reply seen", 64'h1, {63'h0, got});
    check("reply char", {56'h0, exp}, {56'h0, c});
  endtask

  // close, open, range errors and reset command
  task automatic test_commands();
    logic [7:0] c;
    bit         got;
    cmd_reply("CLOSE 9.02\n", 8'h4b);
    check("coil", 64'h0000_0000_0000_0004, coil);
    cmd_reply("CLOSE 9.63\n", 8'h4b);
    check("coil", 64'h8000_0000_0000_0004, coil);
    cmd_reply("CLOSE 9.64\n", 8'h45);
    cmd_reply("CLOSE 13.01\n", 8'h45);
    cmd_reply("CLOSE 9.2\n", 8'h45);
    check("coil", 64'h8000_0000_0000_0004, coil);
    cmd_reply("OPEN 9.02\n", 8'h4b);
    check("coil", 64'h8000_0000_0000_0000, coil);
    // a valid command for another module address gets no reply
    host.send_text("CLOSE 5.01\n");
    host.get_reply(c, got);
    check("foreign reply", 64'h0, {63'h0, got});
    check("coil", 64'h8000_0000_0000_0000, coil);
    cmd_reply("RESET\n", 8'h4b);
    check("coil", 64'h0000_0000_0000_0000, coil);
    $display("test commands done");
  endtask

  // bus reset releases a closed relay
  task automatic test_bus_reset();
    cmd_reply("CLOSE 9.10\n", 8'h4b);
    check("coil", 64'h0000_0000_0000_0400, coil);
    bus_reset = 1'b1;
    repeat (4) @(posedge clk_in);
    #1;
    check("coil", 64'h0000_0000_0000_0000, coil);
    bus_reset = 1'b0;
    repeat (4) @(posedge clk_in);
    #1;
    $display("test bus reset done");
  endtask

  // direct writes, status read, then back to commands
  task automatic test_direct();
    direct_mode = 1'b1;
    repeat (5) @(posedge clk_in);
    #1;
    check("cmd ready", 64'h0, {63'h0, cmd_ready});
    host_wr = '{valid: 1'b1, index: 3'h2, data: 8'h05};
    @(posedge clk_in);
    #1;
    host_wr = '{valid: 1'b1, index: 3'h7, data: 8'hff};
    check("coil", 64'h0000_0000_0005_0000, coil);
    @(posedge clk_in);
    #1;
    host_wr.valid = 1'b0;
    check("coil", 64'hff00_0000_0005_0000, coil);
    readback     = 64'h0123_4567_89ab_cdef;
    status_index = 3'h5;
    repeat (4) @(posedge clk_in);
    #1;
    check("status", 64'h45, {56'h0, status_data});
    direct_mode = 1'b0;
    repeat (5) @(posedge clk_in);
    #1;
    cmd_reply("CLOSE 9.17\n", 8'h4b);
    check("coil", 64'hff00_0000_0002_0000, coil);
    $display("test direct done");
  endtask

  // counts and verdict
  task automatic complete_run();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // watchdog well past the expected run length
  initial begin
    #200_000;
    miscompares++;
    complete_run();
  end

  // reset then the tests in turn
  initial begin
    direct_mode  = 1'b0;
    bus_reset    = 1'b0;
    dip          = 4'h9; // the only module, address unique
    readback     = 64'h0000_0000_0000_0000;
    status_index = 3'h0;
    host_wr      = '0;
    repeat (6) @(posedge clk_in);
    #1;
    rst_in = 1'b0;
    repeat (3) @(posedge clk_in);
    #1;
    check("coil", 64'h0000_0000_0000_0000, coil);
    test_commands();
    test_bus_reset();
    test_direct();
    complete_run();
  end
endmodule // testbench

/* File: verilog/cmd_text_parser.sv */
// Purpose: parse ASCII switch commands into one command record
// Assumes: one char per accepted cycle, LF ends a command
// Notes:   result is a one-cycle pulse the cycle after the LF
`timescale 1ns/1ps
`include "relay_switch_map.svh"

module cmd_text_parser (
  // clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  rst_in,
  // character stream
  input  wire logic                  flush_in,
  input  wire logic                  char_valid_in,
  input  wire logic [7:0]            char_in,
  // parsed command
  output relay_switch_pkg::cmd_s     cmd_out
);

  relay_switch_pkg::parse_s p_reg;
  relay_switch_pkg::parse_s p_next;
  logic                     is_digit;
  logic [6:0]               digit;
  logic                     done;
  logic                     ok;

  // ----------------------------------------------------------------
  // next-state: keyword, address, period, two-digit channel
  // ----------------------------------------------------------------
  always_comb begin
    p_next = p_reg;
    p_next.out.valid = 1'b0;
    is_digit = (char_in >= `RS_CH_ZERO) && (char_in <= `RS_CH_NINE);
    digit = {3'h0, char_in[3:0]};
    done = 1'b0;
    ok = 1'b0;
    if (char_valid_in) begin
      case (p_reg.state)
        relay_switch_pkg::P_WORD: begin
          if (char_in == `RS_CH_SPACE) begin
            if (p_reg.word == `RS_WORD_CLOSE) begin
              p_next.op = relay_switch_pkg::OP_CLOSE;
              p_next.state = relay_switch_pkg::P_ADDR;
            end else if (p_reg.word == `RS_WORD_OPEN) begin
              p_next.op = relay_switch_pkg::OP_OPEN;
              p_next.state = relay_switch_pkg::P_ADDR;
            end else begin
              p_next.state = relay_switch_pkg::P_SKIP;
            end
          end else if (char_in == `RS_CH_LF) begin
            p_next.op = relay_switch_pkg::OP_RESET;
            done = 1'b1;
            ok = (p_reg.word == `RS_WORD_RESET);
          end else begin
            p_next.word = {p_reg.word[31:0], char_in};
          end
        end
        relay_switch_pkg::P_ADDR: begin
          if (is_digit && p_reg.adig != `RS_CHAN_DIGITS) begin
            p_next.addr = 7'(p_reg.addr * 7'd10) + digit;
            p_next.adig = p_reg.adig + 2'h1;
          end else if (char_in == `RS_CH_DOT && p_reg.adig != 2'h0) begin
            p_next.state = relay_switch_pkg::P_CHAN;
          end else if (char_in == `RS_CH_LF) begin
            done = 1'b1;
          end else begin
            p_next.state = relay_switch_pkg::P_SKIP;
          end
        end
        relay_switch_pkg::P_CHAN: begin
          if (is_digit && p_reg.cdig != `RS_CHAN_DIGITS) begin
            p_next.chan = 7'(p_reg.chan * 7'd10) + digit;
            p_next.cdig = p_reg.cdig + 2'h1;
          end else if (char_in == `RS_CH_LF) begin
            done = 1'b1;
            // exactly two digits, channel and address in range
            ok = (p_reg.cdig == `RS_CHAN_DIGITS) &&
                 (p_reg.chan <= `RS_CHAN_MAX) &&
                 (p_reg.addr >= `RS_ADDR_MIN) &&
                 (p_reg.addr <= `RS_ADDR_MAX);
          end else begin
            p_next.state = relay_switch_pkg::P_SKIP;
          end
        end
        relay_switch_pkg::P_SKIP: begin
          done = (char_in == `RS_CH_LF);
        end
        default: begin
          p_next.state = relay_switch_pkg::P_WORD;
        end
      endcase
    end
    // emit the record and rearm for the next command
    if (done) begin
      p_next.out.valid = 1'b1;
      p_next.out.err = !ok;
      p_next.out.op = p_next.op;
      p_next.out.addr = p_reg.addr;
      p_next.out.chan = p_reg.chan[5:0];
      p_next.state = relay_switch_pkg::P_WORD;
      p_next.word = '0;
      p_next.addr = '0;
      p_next.adig = '0;
      p_next.chan = '0;
      p_next.cdig = '0;
    end
    if (flush_in) begin
      p_next = '0;
      p_next.state = relay_switch_pkg::P_WORD;
      p_next.op = relay_switch_pkg::OP_RESET;
      p_next.out.op = relay_switch_pkg::OP_RESET;
    end
  end

  // state register
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      p_reg <= '0;
      p_reg.state <= relay_switch_pkg::P_WORD;
      p_reg.op <= relay_switch_pkg::OP_RESET;
      p_reg.out.op <= relay_switch_pkg::OP_RESET;
    end else begin
      p_reg <= p_next;
    end
  end

  assign cmd_out = p_reg.out;

endmodule // cmd_text_parser

/* File: verilog/relay_switch_map.svh */
// Purpose: constants for the relay switch mode controller
// Assumes: 50 MHz clk_in, ASCII command text, 64 relay channels
// Notes:   timing counts derive from the clock period below
`ifndef RELAY_SWITCH_MAP_SVH
`define RELAY_SWITCH_MAP_SVH

// ----------------------------------------------------------------
// characters and keywords
// ----------------------------------------------------------------
`define RS_CH_SPACE   8'h20
`define RS_CH_LF      8'h0a
`define RS_CH_DOT     8'h2e
`define RS_CH_ZERO    8'h30
`define RS_CH_NINE    8'h39
`define RS_WORD_CLOSE 40'h43_4c4f_5345
`define RS_WORD_OPEN  40'h00_4f50_454e
`define RS_WORD_RESET 40'h52_4553_4554
`define RS_REPLY_OK   8'h4b
`define RS_REPLY_ERR  8'h45

// ----------------------------------------------------------------
// ranges, reset values and timing
// ----------------------------------------------------------------
`define RS_ADDR_MIN     7'h01
`define RS_ADDR_MAX     7'h0c
`define RS_CHAN_MAX     7'h3f
`define RS_CHAN_DIGITS  2'h2
`define RS_COIL_RESET   64'h0000_0000_0000_0000
`define RS_CLK_PERIOD_NS 20
`define RS_DIRECT_OP_NS  9000
`define RS_DIRECT_OP_CYC (`RS_DIRECT_OP_NS / `RS_CLK_PERIOD_NS)

`endif

/* File: verilog/relay_switch_mode_control.sv */
// Purpose: relay control path with command and direct register modes
// Assumes: mode, bus reset, address switch and readback are async pins
// Notes:   coil bytes are the control registers, read back via status
`timescale 1ns/1ps
`include "relay_switch_map.svh"

module relay_switch_mode_control (
  // clock and reset
  input  wire logic                     clk_in,
  input  wire logic                     rst_in,
  // pins from outside the clock domain
  input  wire logic                     direct_mode_in,
  input  wire logic                     bus_reset_in,
  input  wire logic [3:0]               address_dip_switch_in,
  input  wire logic [63:0]              coil_readback_in,
  // command text in
  input  wire logic                     cmd_valid_in,
  input  wire logic [7:0]               cmd_char_in,
  output logic                          cmd_ready_out,
  // reply text out
  output logic                          reply_valid_out,
  output logic [7:0]                    reply_char_out,
  input  wire logic                     reply_ready_in,
  // direct register access
  input  wire relay_switch_pkg::host_wr_s host_wr_in,
  input  wire logic [2:0]               status_index_in,
  output logic [7:0]                    status_data_out,
  // relay drive
  output logic [63:0]                   relay_coil_out
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  localparam int DIRECT_MAX = `RS_DIRECT_OP_CYC;

  relay_switch_pkg::ctl_s st_reg;
  relay_switch_pkg::ctl_s st_next;
  relay_switch_pkg::cmd_s cmd;
  logic                   cmd_take;
  logic                   cmd_mine;
  logic [2:0]             cmd_byte;

  // pick one byte of a 64-bit relay vector
  function automatic logic [7:0] byte_of(input logic [63:0] vec,
                                         input logic [2:0]  idx);
    logic [7:0] b;
    b = '0;
    for (int i = 0; i < 8; i++) begin
      if (idx == 3'(i)) begin
        b = vec[i*8 +: 8];
      end
    end
    return b;
  endfunction

  // replace one whole byte, so its eight relays move together
  function automatic logic [63:0] set_byte(input logic [63:0] vec,
                                           input logic [2:0]  idx,
                                           input logic [7:0]  b);
    logic [63:0] v;
    v = vec;
    for (int i = 0; i < 8; i++) begin
      if (idx == 3'(i)) begin
        v[i*8 +: 8] = b;
      end
    end
    return v;
  endfunction

  // ----------------------------------------------------------------
  // command text parser
  // ----------------------------------------------------------------
  cmd_text_parser u_parser (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .flush_in      (st_reg.mode_q),
    .char_valid_in (cmd_valid_in && cmd_ready_out),
    .char_in       (cmd_char_in),
    .cmd_out       (cmd)
  );

  // command decode: reset is global, open and close need our address
  assign cmd_take = (st_reg.state == relay_switch_pkg::CTL_IDLE) &&
                    !st_reg.mode_q && cmd.valid;
  assign cmd_mine = (cmd.addr == {3'h0, st_reg.dip_q});
  assign cmd_byte = cmd.chan[5:3];

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    // two-stage synchronisers for the outside pins
    st_next.mode_meta = direct_mode_in;
    st_next.mode_q = st_reg.mode_meta;
    st_next.brst_meta = bus_reset_in;
    st_next.brst_q = st_reg.brst_meta;
    st_next.dip_meta = address_dip_switch_in;
    st_next.dip_q = st_reg.dip_meta;
    st_next.rb_meta = coil_readback_in;
    st_next.rb_q = st_reg.rb_meta;
    // status byte read back from the coils
    st_next.rd_data = byte_of(st_reg.rb_q, status_index_in);
    case (st_reg.state)
      relay_switch_pkg::CTL_IDLE: begin
        if (st_reg.mode_q) begin
          st_next.state = relay_switch_pkg::CTL_DIRECT;
        end else if (cmd.valid) begin
          st_next.reply_valid = 1'b1;
          st_next.reply_char = `RS_REPLY_OK;
          st_next.state = relay_switch_pkg::CTL_REPLY;
          if (cmd.err) begin
            st_next.reply_char = `RS_REPLY_ERR;
          end else if (cmd.op == relay_switch_pkg::OP_RESET) begin
            st_next.record = `RS_COIL_RESET;
            st_next.coil = `RS_COIL_RESET;
          end else if (cmd_mine) begin
            // update the record, then write that register's byte
            st_next.record[cmd.chan] =
              (cmd.op == relay_switch_pkg::OP_CLOSE);
            st_next.coil = set_byte(st_reg.coil, cmd_byte,
                             byte_of(st_next.record, cmd_byte));
          end else begin
            // another module's address: stay silent
            st_next.reply_valid = 1'b0;
            st_next.state = relay_switch_pkg::CTL_IDLE;
          end
        end
      end
      relay_switch_pkg::CTL_REPLY: begin
        if (st_reg.mode_q) begin
          st_next.reply_valid = 1'b0;
          st_next.state = relay_switch_pkg::CTL_DIRECT;
        end else if (reply_ready_in) begin
          st_next.reply_valid = 1'b0;
          st_next.state = relay_switch_pkg::CTL_IDLE;
        end
      end
      relay_switch_pkg::CTL_DIRECT: begin
        if (!st_reg.mode_q) begin
          st_next.state = relay_switch_pkg::CTL_IDLE;
        end else if (host_wr_in.valid) begin
          // host owns the coils, one-cycle write; record untouched
          st_next.coil = set_byte(st_reg.coil, host_wr_in.index,
                                  host_wr_in.data);
        end
      end
      default: begin
        st_next.state = relay_switch_pkg::CTL_IDLE;
      end
    endcase
    // bus hard or soft reset opens everything
    if (st_reg.brst_q) begin
      st_next.coil = `RS_COIL_RESET;
      st_next.record = `RS_COIL_RESET;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_reg <= '0;
      st_reg.state <= relay_switch_pkg::CTL_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs
  assign cmd_ready_out = (st_reg.state == relay_switch_pkg::CTL_IDLE) &&
                         !st_reg.mode_q;
  assign reply_valid_out = st_reg.reply_valid;
  assign reply_char_out = st_reg.reply_char;
  assign status_data_out = st_reg.rd_data;
  assign relay_coil_out = st_reg.coil;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_direct_write;
    @(posedge clk_in) disable iff (rst_in)
      (st_reg.state == relay_switch_pkg::CTL_DIRECT && st_reg.mode_q &&
       host_wr_in.valid && !st_reg.brst_q)
      |=> (byte_of(st_reg.coil, $past(host_wr_in.index)) ==
           $past(host_wr_in.data));
  endproperty
  a_direct_write: assert property (p_direct_write)
    else $error("direct write did not reach the coil byte");

  property p_direct_time;
    @(posedge clk_in) disable iff (rst_in)
      (st_reg.state == relay_switch_pkg::CTL_DIRECT && st_reg.mode_q &&
       host_wr_in.valid && !st_reg.brst_q)
      |-> ##[1:DIRECT_MAX] (byte_of(relay_coil_out,
                                    $past(host_wr_in.index)) ==
                            $past(host_wr_in.data));
  endproperty
  a_direct_time: assert property (p_direct_time)
    else $error("direct relay operation too slow");

  property p_record_frozen;
    @(posedge clk_in) disable iff (rst_in)
      (st_reg.state == relay_switch_pkg::CTL_DIRECT && !st_reg.brst_q)
      |=> $stable(st_reg.record);
  endproperty
  a_record_frozen: assert property (p_record_frozen)
    else $error("relay record changed in direct mode");

  property p_no_cmd_direct;
    @(posedge clk_in) disable iff (rst_in)
      (st_reg.state == relay_switch_pkg::CTL_DIRECT) |->
        !cmd_ready_out && !reply_valid_out;
  endproperty
  a_no_cmd_direct: assert property (p_no_cmd_direct)
    else $error("command path active in direct mode");

  property p_close;
    @(posedge clk_in) disable iff (rst_in)
      (cmd_take && !cmd.err && cmd_mine && !st_reg.brst_q &&
       cmd.op == relay_switch_pkg::OP_CLOSE)
      |=> relay_coil_out[$past(cmd.chan)] && st_reg.record[$past(cmd.chan)];
  endproperty
  a_close: assert property (p_close)
    else $error("close did not energise the relay");

  property p_open;
    @(posedge clk_in) disable iff (rst_in)
      (cmd_take && !cmd.err && cmd_mine &&
       cmd.op == relay_switch_pkg::OP_OPEN)
      |=> !relay_coil_out[$past(cmd.chan)];
  endproperty
  a_open: assert property (p_open)
    else $error("open did not release the relay");

  property p_coil_follows;
    @(posedge clk_in) disable iff (rst_in)
      (cmd_take && !cmd.err && cmd_mine)
      |=> (byte_of(st_reg.coil, $past(cmd_byte)) ==
           byte_of(st_reg.record, $past(cmd_byte)));
  endproperty
  a_coil_follows: assert property (p_coil_follows)
    else $error("coil byte differs from record after command");

  property p_foreign;
    @(posedge clk_in) disable iff (rst_in)
      (cmd_take && !cmd.err && !cmd_mine && !st_reg.brst_q &&
       cmd.op != relay_switch_pkg::OP_RESET)
      |=> $stable(relay_coil_out) && !reply_valid_out;
  endproperty
  a_foreign: assert property (p_foreign)
    else $error("command for another address acted on");

  property p_bad_reply;
    @(posedge clk_in) disable iff (rst_in)
      (cmd_take && cmd.err && !st_reg.brst_q) |=>
        reply_valid_out && (reply_char_out == `RS_REPLY_ERR) &&
        $stable(st_reg.record);
  endproperty
  a_bad_reply: assert property (p_bad_reply)
    else $error("bad command not answered with error");

  property p_bus_reset;
    @(posedge clk_in) disable iff (rst_in)
      st_reg.brst_q |=> (relay_coil_out == `RS_COIL_RESET) &&
                        (st_reg.record == `RS_COIL_RESET);
  endproperty
  a_bus_reset: assert property (p_bus_reset)
    else $error("bus reset left a relay closed");

  property p_status;
    @(posedge clk_in) disable iff (rst_in)
      1'b1 ##1 1'b1 |-> (status_data_out ==
        byte_of($past(st_reg.rb_q), $past(status_index_in)));
  endproperty
  a_status: assert property (p_status)
    else $error("status byte does not match readback");

endmodule // relay_switch_mode_control

/* File: verilog/relay_switch_pkg.sv */
// Purpose: types shared by the relay switch controller files
// Assumes: constants live in relay_switch_map.svh
// Notes:   one-hot encodings are written out
package relay_switch_pkg;

  // ----------------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_CLOSE = 3'b001,
    OP_OPEN  = 3'b010,
    OP_RESET = 3'b100
  } op_e;

  typedef enum logic [3:0] {
    P_WORD = 4'b0001,
    P_ADDR = 4'b0010,
    P_CHAN = 4'b0100,
    P_SKIP = 4'b1000
  } parse_state_e;

  typedef enum logic [2:0] {
    CTL_IDLE   = 3'b001,
    CTL_REPLY  = 3'b010,
    CTL_DIRECT = 3'b100
  } ctl_state_e;

  // ----------------------------------------------------------------
  // carriers and state records
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       valid;
    logic       err;
    op_e        op;
    logic [6:0] addr;
    logic [5:0] chan;
  } cmd_s;

  typedef struct packed {
    logic       valid;
    logic [2:0] index;
    logic [7:0] data;
  } host_wr_s;

  typedef struct packed {
    parse_state_e state;
    logic [39:0]  word;
    logic [6:0]   addr;
    logic [1:0]   adig;
    logic [6:0]   chan;
    logic [1:0]   cdig;
    op_e          op;
    cmd_s         out;
  } parse_s;

  typedef struct packed {
    ctl_state_e  state;
    logic        mode_meta;
    logic        mode_q;
    logic        brst_meta;
    logic        brst_q;
    logic [3:0]  dip_meta;
    logic [3:0]  dip_q;
    logic [63:0] rb_meta;
    logic [63:0] rb_q;
    logic [63:0] coil;
    logic [63:0] record;
    logic [7:0]  rd_data;
    logic        reply_valid;
    logic [7:0]  reply_char;
  } ctl_s;

endpackage
